// [squid_cmd_map.svh]
// Purpose: Constants for the remote setting-command interpreter.
// Assumes: Commands arrive already parsed as opcode, channel and value.
// Notes: Times are whole seconds counted from a 25 MHz clock.
// Behaviour
// RQ1: Acquisition stop halts the sample stream and returns the panel to run.
// RQ2: Display channel accepts 1 to 4; resets to channel 1.
// RQ3: Loop clock role 0 is slave, 1 is master; default master.
// RQ4: Gain codes 1-9 for channels 1-3, 1-6 for channel 4; default x1.
// RQ5: Heater command heats, cools down, then auto-tunes; panel shows heater active.
// RQ6: Heat time 1-50 s default 10; cool-down 1-50 default 12.
// RQ7: High-pass 0 is DC, 1 is 0.3 Hz, channels 1-4, default DC.
// RQ8: System state 0 off, 1 run, 2 manual tune, 3 autotune; default off.
// RQ9: Off hides samples; run displays samples and permits acquisition start.
// RQ10: Autotune tunes each active channel in turn; status readable throughout.
// RQ11: Slow slew only when channel gain is x100 or higher; default normal.
// RQ12: GPIB lockout lights remote lamp, locks keypad until local key or value 0.
// RQ13: Serial lockout value 1 locks keypad, remote lamp unchanged.
// RQ14: Low-pass 0 off, 1 500 Hz, 2 5000 Hz, 3 5 Hz; default off.
// RQ15: Offset for channels 1-3 accepts -100 to +100; default 0.
// RQ16: Packet size 1 to 16 samples; default 16.
// RQ17: Bias, modulation and skew are 0-100 percent for channels 1-3; default 0.
// RQ18: Channels 1-3 off, low or high temp; channel 4 off/on; channel 1 low.
// RQ19: Good-tune voltage 0 to 4.5, default 2.0.
// RQ20: Enabled command errors set event bit 5; execution errors event bit 4.
// RQ21: Command mask bit 0 unknown, bit 1 unterminated, bit 2 bad parameter.
// RQ22: Execution mask bits 0-4: tx underflow, rx overflow, bus, parity, tx overflow.
// RQ23: Reading an error register returns its contents then clears it.
// RQ24: After acquisition start, stream continuously over GPIB until stopped.
// RQ25: Out-of-range parameter keeps the setting and flags a bad-parameter error.
`ifndef SQUID_CMD_MAP_SVH
`define SQUID_CMD_MAP_SVH

// ==========================================================
// Timing
`define CLK_HZ 32'd25000000
`define TUNE_STEP_CYCLES 16'd1000

// ==========================================================
// Ranges and defaults
`define CHAN_LO 3'd1
`define LOOP_CHANS 3'd3
`define AUX_CHAN 3'd4
`define GAIN_MAX_LOOP 4'd9
`define GAIN_MAX_AUX 4'd6
`define GAIN_DEF 4'd1
`define GAIN_SLOW_MIN 4'd7
`define OFFSET_MIN (-8'sd100)
`define OFFSET_MAX 8'sd100
`define PCT_MAX 7'd100
`define PACKET_MAX 5'd16
`define TIME_MAX 6'd50
`define HEAT_DEF 6'd10
`define WAIT_DEF 6'd12
`define VOLT_MAX 6'd45
`define VOLT_DEF 6'd20
`define LP_MAX 2'd3
`define SENSOR_MAX 2'd2
`define SENSOR_LTS 2'd1

// ==========================================================
// Error bits
`define CE_UNKNOWN 0
`define CE_UNTERM 1
`define CE_BADPARAM 2
`define ESR_EXEC 4
`define ESR_CMD 5
`define ERR_SEL_CMD 2'd1
`define ERR_SEL_EXEC 2'd2
`define CMD_MASK_USED 8'h07
`define EXEC_MASK_USED 8'h1f

`endif

// [squid_cmd_pkg.sv]
// Purpose: Types for the setting-command interpreter.
// Assumes: Used with squid_cmd_map.svh.
// Notes: Command codes are arbitrary internal encodings.
package squid_cmd_pkg;

	typedef enum logic [4:0] {
		OP_ACQ_STOP = 5'h00,
		OP_ACQ_START = 5'h01,
		OP_DISP_CHAN = 5'h02,
		OP_CLK_ROLE = 5'h03,
		OP_GAIN = 5'h04,
		OP_HEAT = 5'h05,
		OP_HPF = 5'h06,
		OP_STATE = 5'h07,
		OP_SLEW = 5'h08,
		OP_LOCK = 5'h09,
		OP_LPF = 5'h0a,
		OP_OFFSET = 5'h0b,
		OP_PACKET = 5'h0c,
		OP_NBIAS = 5'h0d,
		OP_PBIAS = 5'h0e,
		OP_MOD = 5'h0f,
		OP_SKEW = 5'h10,
		OP_CHAN_CFG = 5'h11,
		OP_HEAT_TIME = 5'h12,
		OP_VOLT = 5'h13,
		OP_WAIT_TIME = 5'h14,
		OP_ERR_EN = 5'h15,
		OP_ERR_READ = 5'h16
	} opcode_t;

	typedef enum logic [1:0] {
		SYS_OFF = 2'b00,
		SYS_RUN = 2'b01,
		SYS_MANUAL = 2'b10,
		SYS_AUTOTUNE = 2'b11
	} sys_state_t;

	typedef enum logic [1:0] {
		HT_IDLE = 2'b00,
		HT_HEAT = 2'b01,
		HT_COOL = 2'b10
	} heat_state_t;

	typedef struct packed {
		opcode_t op;
		logic [2:0] chan;
		logic [15:0] value;
		logic unterminated;
		logic from_serial;
	} cmd_t;

	typedef struct packed {
		logic [3:0] gain;
		logic hpf;
		logic [1:0] lpf;
		logic slow_slew;
		logic [7:0] offset;
		logic [6:0] pbias;
		logic [6:0] nbias;
		logic [6:0] modul;
		logic [6:0] skew;
		logic [1:0] sensor;
	} chan_cfg_t;

	typedef struct packed {
		logic [1:0] st3;
		logic [1:0] st2;
		logic [1:0] st1;
	} tune_stat_t;

endpackage

// [squid_cmd_ctrl.sv]
// Purpose: Executes parsed setting commands and owns the system settings.
// Assumes: The text parser outside delivers one command per cmd_valid pulse.
// Notes: Unknown command and bus errors arrive as pulses from the link side.
`timescale 1ns/10ps
`default_nettype none
`include "squid_cmd_map.svh"

module squid_cmd_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Parsed command
	input wire logic cmd_valid,
	input var squid_cmd_pkg::cmd_t cmd,
	input wire logic unknown_cmd,
	input wire logic [4:0] exec_err,
	// Panel and tune feedback
	input wire logic local_key,
	input wire logic [2:0] tune_fail,
	// Per-channel configuration
	output squid_cmd_pkg::chan_cfg_t cfg1,
	output squid_cmd_pkg::chan_cfg_t cfg2,
	output squid_cmd_pkg::chan_cfg_t cfg3,
	output squid_cmd_pkg::chan_cfg_t cfg4,
	// System settings
	output squid_cmd_pkg::sys_state_t sys_state,
	output logic [2:0] display_channel,
	output logic loop_clock_master,
	output logic aux_enable,
	output logic [5:0] heat_time,
	output logic [5:0] cooldown_time,
	output logic [5:0] good_tune_volt,
	output logic [4:0] packet_size,
	output logic samples_shown,
	output logic streaming,
	output logic heater_on,
	output logic heater_indicator,
	output logic keypad_locked,
	output logic remote_indicator,
	output squid_cmd_pkg::tune_stat_t tune_status,
	// Error reporting
	output logic [7:0] command_error_enable,
	output logic [7:0] execution_error_enable,
	output logic [7:0] err_read_data,
	output logic err_read_valid,
	output logic [7:0] event_status
);
	import squid_cmd_pkg::*;

	chan_cfg_t cfg [1:4];
	logic [7:0] cmd_err;
	logic [7:0] exec_err_reg;
	logic bad_param;
	logic [5:0] heat_secs;
	logic [24:0] sec_cnt;
	heat_state_t heat_st;
	logic start_tune;
	logic [1:0] tune_ch;
	logic [15:0] tune_cnt;
	logic tuning;
	logic [2:0] ch;
	logic [15:0] v;
	logic loop_ch;
	logic any_ch;
	logic pct_ok;

	assign cfg1 = cfg[1];
	assign cfg2 = cfg[2];
	assign cfg3 = cfg[3];
	assign cfg4 = cfg[4];
	assign ch = cmd.chan;
	assign v = cmd.value;
	assign loop_ch = (ch >= `CHAN_LO) && (ch <= `LOOP_CHANS);
	assign any_ch = (ch >= `CHAN_LO) && (ch <= `AUX_CHAN);
	assign pct_ok = loop_ch && (v <= 16'(`PCT_MAX));

	// ==========================================================
	// Parameter check
	// Values are unsigned except offset, which is two's complement.
	always_comb begin
		bad_param = 1'b0;
		case (cmd.op)
			OP_DISP_CHAN: bad_param = !(v >= 16'd1 && v <= 16'(`AUX_CHAN)); // RQ2
			OP_CLK_ROLE: bad_param = v > 16'd1;
			OP_GAIN: bad_param = !any_ch || v < 16'd1 ||
				v > ((ch == `AUX_CHAN) ? 16'(`GAIN_MAX_AUX) : 16'(`GAIN_MAX_LOOP)); // RQ4
			OP_HPF: bad_param = !any_ch || v > 16'd1;
			OP_STATE: bad_param = v > 16'd3;
			OP_SLEW: bad_param = !loop_ch || v > 16'd1 ||
				(v == 16'd1 && cfg[ch].gain < `GAIN_SLOW_MIN); // RQ11
			OP_LOCK: bad_param = v > 16'd1;
			OP_LPF: bad_param = !any_ch || v > 16'(`LP_MAX);
			OP_OFFSET: bad_param = !loop_ch || $signed(v) < -16'sd100 ||
				$signed(v) > 16'sd100; // RQ15
			OP_PACKET: bad_param = v < 16'd1 || v > 16'(`PACKET_MAX); // RQ16
			OP_NBIAS, OP_PBIAS, OP_MOD, OP_SKEW: bad_param = !pct_ok; // RQ17
			OP_CHAN_CFG: bad_param = !any_ch ||
				v > ((ch == `AUX_CHAN) ? 16'd1 : 16'(`SENSOR_MAX)); // RQ18
			OP_HEAT_TIME, OP_WAIT_TIME: bad_param = v < 16'd1 || v > 16'(`TIME_MAX); // RQ6
			OP_VOLT: bad_param = v > 16'(`VOLT_MAX); // RQ19
			OP_ERR_EN: bad_param = !(ch == 3'(`ERR_SEL_CMD) || ch == 3'(`ERR_SEL_EXEC)) ||
				v > 16'd255;
			OP_ERR_READ: bad_param = !(ch == 3'(`ERR_SEL_CMD) || ch == 3'(`ERR_SEL_EXEC));
			default: bad_param = 1'b0;
		endcase
	end

	// ==========================================================
	// Per-channel settings
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 1; i <= 4; i++) begin
				cfg[i] <= '0;
				cfg[i].gain <= `GAIN_DEF; // RQ4
			end
			cfg[1].sensor <= `SENSOR_LTS; // RQ18
		end else if (cmd_valid && !cmd.unterminated && !bad_param) begin // RQ25
			case (cmd.op)
				OP_GAIN: begin
					cfg[ch].gain <= v[3:0];
					// Dropping below x100 forces slew back so it never stays illegal.
					if (v[3:0] < `GAIN_SLOW_MIN)
						cfg[ch].slow_slew <= 1'b0; // RQ11
				end
				OP_HPF: cfg[ch].hpf <= v[0]; // RQ7
				OP_LPF: cfg[ch].lpf <= v[1:0]; // RQ14
				OP_SLEW: cfg[ch].slow_slew <= v[0]; // RQ11
				OP_OFFSET: cfg[ch].offset <= v[7:0]; // RQ15
				OP_PBIAS: cfg[ch].pbias <= v[6:0]; // RQ17
				OP_NBIAS: cfg[ch].nbias <= v[6:0]; // RQ17
				OP_MOD: cfg[ch].modul <= v[6:0]; // RQ17
				OP_SKEW: cfg[ch].skew <= v[6:0]; // RQ17
				OP_CHAN_CFG: cfg[ch].sensor <= v[1:0]; // RQ18
				default: ;
			endcase
		end
	end

	// ==========================================================
	// System settings
	always_ff @(posedge clk) begin
		if (!rstn) begin
			display_channel <= `CHAN_LO; // RQ2
			loop_clock_master <= 1'b1; // RQ3
			heat_time <= `HEAT_DEF; // RQ6
			cooldown_time <= `WAIT_DEF; // RQ6
			good_tune_volt <= `VOLT_DEF; // RQ19
			packet_size <= `PACKET_MAX; // RQ16
			command_error_enable <= 8'h00;
			execution_error_enable <= 8'h00;
		end else if (cmd_valid && !cmd.unterminated && !bad_param) begin
			case (cmd.op)
				OP_DISP_CHAN: display_channel <= v[2:0]; // RQ2
				OP_CLK_ROLE: loop_clock_master <= v[0]; // RQ3
				OP_HEAT_TIME: heat_time <= v[5:0]; // RQ6
				OP_WAIT_TIME: cooldown_time <= v[5:0]; // RQ6
				OP_VOLT: good_tune_volt <= v[5:0]; // RQ19
				OP_PACKET: packet_size <= v[4:0]; // RQ16
				OP_ERR_EN: begin
					if (ch == 3'(`ERR_SEL_CMD))
						command_error_enable <= v[7:0] & `CMD_MASK_USED; // RQ20 RQ21
					else
						execution_error_enable <= v[7:0] & `EXEC_MASK_USED; // RQ22
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			aux_enable <= 1'b0;
		else
			aux_enable <= cfg[4].sensor[0];
	end

	// ==========================================================
	// Heater cycle
	// Timer counts whole seconds; tune starts once cool-down ends.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			heat_st <= HT_IDLE;
			sec_cnt <= '0;
			heat_secs <= '0;
			start_tune <= 1'b0;
		end else begin
			start_tune <= 1'b0;
			case (heat_st)
				HT_IDLE: if (cmd_valid && cmd.op == OP_HEAT && !cmd.unterminated) begin
					heat_st <= HT_HEAT; // RQ5
					sec_cnt <= '0;
					heat_secs <= '0;
				end
				default: begin
					if (sec_cnt == 25'(`CLK_HZ - 1)) begin
						sec_cnt <= '0;
						heat_secs <= heat_secs + 6'd1;
						if (heat_st == HT_HEAT && 6'(heat_secs) + 6'd1 >= heat_time) begin
							heat_st <= HT_COOL;
							heat_secs <= '0;
						end else if (heat_st == HT_COOL &&
								6'(heat_secs) + 6'd1 >= cooldown_time) begin
							heat_st <= HT_IDLE;
							start_tune <= 1'b1; // RQ5
						end
					end else
						sec_cnt <= sec_cnt + 25'd1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			heater_on <= 1'b0;
			heater_indicator <= 1'b0;
		end else begin
			heater_on <= (heat_st == HT_HEAT);
			heater_indicator <= (heat_st != HT_IDLE); // RQ5
		end
	end

	// ==========================================================
	// System state, autotune sequencer and stream
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sys_state <= SYS_OFF; // RQ8
			tuning <= 1'b0;
			tune_ch <= 2'd1;
			tune_cnt <= '0;
			tune_status <= {3{2'd3}};
			streaming <= 1'b0;
		end else begin
			if (start_tune || (cmd_valid && !bad_param && !cmd.unterminated &&
					cmd.op == OP_STATE && v[1:0] == 2'(SYS_AUTOTUNE))) begin
				sys_state <= SYS_AUTOTUNE; // RQ5 RQ10
				tuning <= 1'b1;
				tune_ch <= 2'd1;
				tune_cnt <= '0;
				streaming <= 1'b0;
			end else if (cmd_valid && !bad_param && !cmd.unterminated &&
					cmd.op == OP_STATE) begin
				sys_state <= sys_state_t'(v[1:0]); // RQ8
				tuning <= 1'b0;
				streaming <= 1'b0;
			end else if (cmd_valid && cmd.op == OP_ACQ_STOP && !cmd.unterminated) begin
				streaming <= 1'b0; // RQ1
				sys_state <= SYS_RUN; // RQ1
			end else if (cmd_valid && cmd.op == OP_ACQ_START && !cmd.unterminated &&
					sys_state == SYS_RUN && !cmd.from_serial) begin
				streaming <= 1'b1; // RQ9 RQ24
			end else if (tuning) begin
				// One channel at a time; uninstalled channels are skipped at once.
				if (cfg[tune_ch].sensor == 2'd0) begin
					tune_status[2*(tune_ch-1) +: 2] <= 2'd3; // RQ10
					tune_cnt <= `TUNE_STEP_CYCLES;
				end else if (tune_cnt != `TUNE_STEP_CYCLES)
					tune_status[2*(tune_ch-1) +: 2] <= 2'd2; // RQ10
				if (tune_cnt == `TUNE_STEP_CYCLES || cfg[tune_ch].sensor == 2'd0) begin
					if (cfg[tune_ch].sensor != 2'd0)
						tune_status[2*(tune_ch-1) +: 2] <= {1'b0, tune_fail[tune_ch-1]};
					tune_cnt <= '0;
					if (tune_ch == 2'(`LOOP_CHANS))
						tuning <= 1'b0;
					else
						tune_ch <= tune_ch + 2'd1;
				end else
					tune_cnt <= tune_cnt + 16'd1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			samples_shown <= 1'b0;
		else
			samples_shown <= (sys_state != SYS_OFF); // RQ9
	end

	// ==========================================================
	// Keypad lockout
	always_ff @(posedge clk) begin
		if (!rstn) begin
			keypad_locked <= 1'b0;
			remote_indicator <= 1'b0;
		end else if (cmd_valid && cmd.op == OP_LOCK && !bad_param && !cmd.unterminated) begin
			keypad_locked <= v[0]; // RQ12 RQ13
			if (!cmd.from_serial)
				remote_indicator <= v[0]; // RQ12
		end else if (local_key && !cmd.from_serial) begin
			keypad_locked <= 1'b0; // RQ12
			remote_indicator <= 1'b0;
		end
	end

	// ==========================================================
	// User error registers and event status
	// A new error in the read cycle is kept: set wins over clear.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd_err <= 8'h00;
			exec_err_reg <= 8'h00;
			err_read_data <= 8'h00;
			err_read_valid <= 1'b0;
			event_status <= 8'h00;
		end else begin
			err_read_valid <= 1'b0;
			if (cmd_valid && cmd.op == OP_ERR_READ && !bad_param && !cmd.unterminated) begin
				err_read_valid <= 1'b1; // RQ23
				if (ch == 3'(`ERR_SEL_CMD)) begin
					err_read_data <= cmd_err;
					cmd_err <= 8'h00;
				end else begin
					err_read_data <= exec_err_reg;
					exec_err_reg <= 8'h00;
				end
			end
			if (unknown_cmd)
				cmd_err[`CE_UNKNOWN] <= 1'b1; // RQ21
			if (cmd_valid && cmd.unterminated)
				cmd_err[`CE_UNTERM] <= 1'b1; // RQ21
			if (cmd_valid && !cmd.unterminated && bad_param)
				cmd_err[`CE_BADPARAM] <= 1'b1; // RQ25
			for (int i = 0; i < 5; i++)
				if (exec_err[i])
					exec_err_reg[i] <= 1'b1; // RQ22
			if (|({5'd0, unknown_cmd, cmd_valid && cmd.unterminated,
					cmd_valid && !cmd.unterminated && bad_param} &
					{command_error_enable[7:3], command_error_enable[0],
					command_error_enable[1], command_error_enable[2]}))
				event_status[`ESR_CMD] <= 1'b1; // RQ20
			if (|(exec_err & execution_error_enable[4:0]))
				event_status[`ESR_EXEC] <= 1'b1; // RQ20
		end
	end

endmodule
`default_nettype wire

// [squid_cmd_chk_sva.sv]
// Purpose: Port-level checks on the setting-command interpreter.
// Assumes: One clock, synchronous active-low reset, commands taken on cmd_valid.
// Notes: Refusal is watched on channel 2 gain only, to keep the set small.
`timescale 1ns/10ps
`default_nettype none
module squid_cmd_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Command side
	input wire logic cmd_valid,
	input var squid_cmd_pkg::cmd_t cmd,
	// Observed outputs
	input var squid_cmd_pkg::chan_cfg_t cfg1,
	input var squid_cmd_pkg::chan_cfg_t cfg2,
	input var squid_cmd_pkg::sys_state_t sys_state,
	input wire logic [2:0] display_channel,
	input wire logic [5:0] heat_time,
	input wire logic [4:0] packet_size,
	input wire logic samples_shown,
	input wire logic streaming,
	input wire logic keypad_locked,
	input wire logic remote_indicator,
	input wire logic [7:0] event_status
);
	import squid_cmd_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ====================================
	// Command sequences
	sequence gain2_ok_s;
		cmd_valid && !cmd.unterminated && cmd.op == OP_GAIN && cmd.chan == 3'h2
			&& cmd.value >= 16'h0001 && cmd.value <= 16'h0009;
	endsequence
	sequence gain2_bad_s;
		cmd_valid && cmd.op == OP_GAIN && cmd.chan == 3'h2 && cmd.value > 16'h0009;
	endsequence
	sequence stop_s;
		cmd_valid && cmd.op == OP_ACQ_STOP && !cmd.unterminated;
	endsequence
	sequence lock_s(logic ser);
		cmd_valid && !cmd.unterminated && cmd.op == OP_LOCK && cmd.value == 16'h0001
			&& cmd.from_serial == ser;
	endsequence
	// ====================================
	// Assertions
	gain_update_a: assert property (gain2_ok_s |=> cfg2.gain == $past(cmd.value[3:0]))
		else $error("gain code not taken");
	gain_keep_a: assert property (gain2_bad_s |=> $stable(cfg2.gain))
		else $error("bad gain code changed the setting");
	gain_range_a: assert property (cfg1.gain inside {[4'h1:4'h9]})
		else $error("gain outside its codes");
	slew_gain_a: assert property (cfg1.slow_slew |-> cfg1.gain >= 4'h7)
		else $error("slow slew below x100");
	offset_range_a: assert property ($signed(cfg1.offset) >= -8'sh64
		&& $signed(cfg1.offset) <= 8'sh64) else $error("offset out of range");
	limits_held_a: assert property (heat_time inside {[6'h01:6'h32]}
		&& packet_size inside {[5'h01:5'h10]} && display_channel inside {[3'h1:3'h4]})
		else $error("system setting out of range");
	shown_late_a: assert property ($past(rstn) |->
		samples_shown == ($past(sys_state) != SYS_OFF)) else $error("display state wrong");
	stop_run_a: assert property (stop_s |=> sys_state == SYS_RUN ##[0:1] !streaming)
		else $error("stop did not halt stream");
	gpib_lock_a: assert property (lock_s(1'b0) |=> ##[0:1] (keypad_locked && remote_indicator))
		else $error("lockout not applied");
	serial_lock_a: assert property (lock_s(1'b1) |=> $stable(remote_indicator)
		##[0:1] keypad_locked) else $error("serial lockout wrong");
	event_sticky_a: assert property ($past(rstn) |->
		!$fell(event_status[5]) && !$fell(event_status[4])) else $error("event bit lost");
endmodule
bind squid_cmd_ctrl squid_cmd_chk chk (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
	.cmd(cmd), .cfg1(cfg1), .cfg2(cfg2), .sys_state(sys_state),
	.display_channel(display_channel), .heat_time(heat_time), .packet_size(packet_size),
	.samples_shown(samples_shown), .streaming(streaming), .keypad_locked(keypad_locked),
	.remote_indicator(remote_indicator), .event_status(event_status));
`default_nettype wire

// [host_link.sv]
// Purpose: Host model that delivers one parsed command per request.
// Assumes: The bench raises req for one cycle per command.
// Notes: The idle value field toggles so that no check leans on a stale value.
`timescale 1ns/10ps
`default_nettype none
module host_link (
	// Clock
	input wire logic clk,
	// Request from the bench
	input wire logic req,
	input var squid_cmd_pkg::opcode_t op,
	input wire logic [2:0] chan,
	input wire logic [15:0] val,
	input wire logic ser,
	input wire logic unt,
	// Command towards the interpreter
	output logic cmd_valid,
	output squid_cmd_pkg::cmd_t cmd
);
	import squid_cmd_pkg::*;
	always_ff @(posedge clk) begin
		cmd_valid <= req;
	end
	always_ff @(posedge clk) begin
		if (req) begin
			cmd <= '{op: op, chan: chan, value: val, unterminated: unt, from_serial: ser};
		end else begin
			cmd.value <= ~cmd.value;
		end
	end
endmodule
`default_nettype wire

// [squid_controller_command_set_test.sv]
// Purpose: Self-checking bench for the setting-command interpreter.
// Assumes: Commands reach the design through host_link.
// Notes: Heat periods last seconds, so only their start is seen here.
`timescale 1ns/10ps
`default_nettype none
module squid_controller_command_set_test;
	import squid_cmd_pkg::*;
	typedef struct packed {
		logic [4:0] sel;
		logic [15:0] val;
	} note_t;
	typedef struct packed {
		opcode_t op;
		logic [2:0] ch;
		logic [15:0] v;
		logic [4:0] sel;
		logic [15:0] val;
	} step_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic h_req = 1'b0;
	opcode_t h_op = OP_ACQ_STOP;
	logic [2:0] h_chan = 3'h0;
	logic [15:0] h_val = 16'h0000;
	logic h_ser = 1'b0;
	logic h_unt = 1'b0;
	logic unknown_cmd = 1'b0;
	logic [4:0] exec_err = 5'h00;
	logic local_key = 1'b0;
	logic [2:0] tune_fail = 3'h0;
	logic cmd_valid, aux_enable, samples_shown, streaming, heater_on, heater_indicator;
	logic loop_clock_master, keypad_locked, remote_indicator, err_read_valid, probe;
	cmd_t cmd;
	chan_cfg_t cfg1, cfg2, cfg3, cfg4;
	sys_state_t sys_state;
	tune_stat_t tune_status;
	logic [2:0] display_channel;
	logic [5:0] heat_time, cooldown_time, good_tune_volt;
	logic [4:0] packet_size;
	logic [7:0] command_error_enable, execution_error_enable, err_read_data, event_status;
	logic [15:0] obs [31];
	logic [7:0] lf = 8'h13;
	logic [3:0] gv [4];
	note_t notes[$];
	note_t cur;
	int n_fail = 0;
	int n_checks = 0;
	note_t dflt [21] = '{'{5'h00, 16'h1}, '{5'h01, 16'h1}, '{5'h02, 16'h1}, '{5'h03, 16'h1},
		'{5'h04, 16'h1}, '{5'h05, 16'h0}, '{5'h06, 16'h0}, '{5'h07, 16'h1}, '{5'h08, 16'h1},
		'{5'h09, 16'ha}, '{5'h0a, 16'hc}, '{5'h0b, 16'h14}, '{5'h0c, 16'h10}, '{5'h0d, 16'h0},
		'{5'h13, 16'h0}, '{5'h14, 16'h0}, '{5'h15, 16'h3f}, '{5'h18, 16'h0}, '{5'h19, 16'h0},
		'{5'h1a, 16'h0}, '{5'h1c, 16'h0}};
	step_t steps [20] = '{'{OP_HEAT_TIME, 3'h1, 16'h32, 5'h09, 16'h32},
		'{OP_HEAT_TIME, 3'h1, 16'h33, 5'h09, 16'h32}, '{OP_HEAT_TIME, 3'h1, 16'h0, 5'h09, 16'h32},
		'{OP_WAIT_TIME, 3'h1, 16'h1, 5'h0a, 16'h1}, '{OP_WAIT_TIME, 3'h1, 16'h33, 5'h0a, 16'h1},
		'{OP_VOLT, 3'h1, 16'h2d, 5'h0b, 16'h2d}, '{OP_VOLT, 3'h1, 16'h2e, 5'h0b, 16'h2d},
		'{OP_PACKET, 3'h1, 16'h1, 5'h0c, 16'h1}, '{OP_PACKET, 3'h1, 16'h11, 5'h0c, 16'h1},
		'{OP_DISP_CHAN, 3'h1, 16'h4, 5'h07, 16'h4}, '{OP_DISP_CHAN, 3'h1, 16'h5, 5'h07, 16'h4},
		'{OP_CLK_ROLE, 3'h1, 16'h0, 5'h08, 16'h0}, '{OP_CLK_ROLE, 3'h1, 16'h1, 5'h08, 16'h1},
		'{OP_LPF, 3'h1, 16'h3, 5'h19, 16'h3}, '{OP_HPF, 3'h1, 16'h1, 5'h18, 16'h1},
		'{OP_PBIAS, 3'h1, 16'h64, 5'h1a, 16'h64}, '{OP_PBIAS, 3'h1, 16'h65, 5'h1a, 16'h64},
		'{OP_CHAN_CFG, 3'h2, 16'h2, 5'h05, 16'h2}, '{OP_CHAN_CFG, 3'h2, 16'h3, 5'h05, 16'h2},
		'{OP_CHAN_CFG, 3'h4, 16'h1, 5'h1c, 16'h1}};
	always #20 clk = ~clk;
	host_link host (.clk(clk), .req(h_req), .op(h_op), .chan(h_chan), .val(h_val),
		.ser(h_ser), .unt(h_unt), .cmd_valid(cmd_valid), .cmd(cmd));
	squid_cmd_ctrl dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
		.unknown_cmd(unknown_cmd), .exec_err(exec_err), .local_key(local_key),
		.tune_fail(tune_fail), .cfg1(cfg1), .cfg2(cfg2), .cfg3(cfg3), .cfg4(cfg4),
		.sys_state(sys_state), .display_channel(display_channel),
		.loop_clock_master(loop_clock_master), .aux_enable(aux_enable), .heat_time(heat_time),
		.cooldown_time(cooldown_time), .good_tune_volt(good_tune_volt),
		.packet_size(packet_size), .samples_shown(samples_shown), .streaming(streaming),
		.heater_on(heater_on), .heater_indicator(heater_indicator),
		.keypad_locked(keypad_locked), .remote_indicator(remote_indicator),
		.tune_status(tune_status), .command_error_enable(command_error_enable),
		.execution_error_enable(execution_error_enable), .err_read_data(err_read_data),
		.err_read_valid(err_read_valid), .event_status(event_status));
	always_comb begin
		obs = '{16'(cfg1.gain), 16'(cfg2.gain), 16'(cfg3.gain), 16'(cfg4.gain),
			16'(cfg1.sensor), 16'(cfg2.sensor), 16'(sys_state), 16'(display_channel),
			16'(loop_clock_master), 16'(heat_time), 16'(cooldown_time), 16'(good_tune_volt),
			16'(packet_size), 16'(samples_shown), 16'(streaming), 16'(keypad_locked),
			16'(remote_indicator), 16'(event_status), 16'(command_error_enable),
			16'(cfg1.slow_slew), 16'(cfg1.offset), 16'(tune_status), 16'(heater_on),
			16'(heater_indicator), 16'(cfg1.hpf), 16'(cfg1.lpf), 16'(cfg1.pbias),
			16'(execution_error_enable), 16'(aux_enable), 16'(tune_status.st1),
			16'(err_read_data)};
	end
	// ====================================
	// Tasks
	function automatic logic [7:0] nxt(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			n_fail++;
		end
	endtask
	// Settings are levels, so the note is looked at a few cycles after the take.
	task automatic send(opcode_t op, logic [2:0] ch, logic [15:0] v, logic ser, logic un = 1'b0);
		@(posedge clk);
		#1 h_req = 1'b1;
		{h_op, h_chan, h_val, h_ser, h_unt} = {op, ch, v, ser, un};
		@(posedge clk);
		#1 h_req = 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic note(logic [4:0] sel, logic [15:0] val);
		@(posedge clk);
		#1 probe = 1'b1;
		notes.push_back('{sel, val});
		@(negedge clk);
		#1 probe = 1'b0;
	endtask
	task automatic pulse(logic [6:0] p);
		@(posedge clk);
		#1 {local_key, unknown_cmd, exec_err} = p;
		@(posedge clk);
		#1 {local_key, unknown_cmd, exec_err} = 7'h00;
		repeat (3) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		if (probe === 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			check(obs[cur.sel], cur.val);
		end
	end
	initial begin
		#400000;
		n_fail++;
		summarize();
	end
	// ====================================
	// Scenarios
	initial begin
		probe = 1'b0;
		repeat (2) @(posedge clk);
		#1 rstn = 1'b1;
		foreach (dflt[i]) begin
			note(dflt[i].sel, dflt[i].val);
		end
		for (int c = 1; c <= 3; c++) begin
			lf = nxt(lf);
			gv[c] = 4'(lf % 8'h09) + 4'h1;
			send(OP_GAIN, 3'(c), 16'(gv[c]), 1'b0);
			note(5'(c - 1), 16'(gv[c]));
		end
		send(OP_GAIN, 3'h2, 16'(lf) + 16'h000a, 1'b0);
		note(5'h01, 16'(gv[2]));
		send(OP_GAIN, 3'h3, 16'(gv[3] ^ 4'h1), 1'b0, 1'b1);
		note(5'h02, 16'(gv[3]));
		send(OP_GAIN, 3'h4, 16'h0007, 1'b0);
		note(5'h03, 16'h0001);
		send(OP_GAIN, 3'h4, 16'h0006, 1'b0);
		note(5'h03, 16'h0006);
		send(OP_GAIN, 3'h1, 16'h0006, 1'b0);
		send(OP_SLEW, 3'h1, 16'h0001, 1'b0);
		note(5'h13, 16'h0000);
		send(OP_GAIN, 3'h1, 16'h0007, 1'b0);
		send(OP_SLEW, 3'h1, 16'h0001, 1'b0);
		note(5'h13, 16'h0001);
		send(OP_OFFSET, 3'h1, 16'hff9c, 1'b0);
		send(OP_OFFSET, 3'h1, 16'hff9b, 1'b0);
		note(5'h14, 16'h009c);
		foreach (steps[i]) begin
			send(steps[i].op, steps[i].ch, steps[i].v, 1'b0);
			note(steps[i].sel, steps[i].val);
		end
		send(OP_PACKET, 3'h1, 16'h0000, 1'b0);
		note(5'h11, 16'h0000);
		send(OP_ERR_EN, 3'h1, 16'h0001, 1'b0);
		note(5'h12, 16'h0001);
		send(OP_PACKET, 3'h1, 16'h0011, 1'b0);
		note(5'h11, 16'h0000);
		pulse(7'h20);
		note(5'h11, 16'h0020);
		send(OP_ERR_EN, 3'h2, 16'h0008, 1'b0);
		note(5'h1b, 16'h0008);
		pulse(7'h04);
		note(5'h11, 16'h0020);
		pulse(7'h08);
		note(5'h11, 16'h0030);
		send(OP_ERR_READ, 3'h2, 16'h0, 1'b0);
		note(5'h1e, 16'h000c);
		send(OP_ERR_READ, 3'h2, 16'h0, 1'b0);
		note(5'h1e, 16'h0000);
		send(OP_STATE, 3'h1, 16'h0001, 1'b0);
		note(5'h0d, 16'h0001);
		send(OP_ACQ_START, 3'h1, 16'h0000, 1'b1);
		note(5'h0e, 16'h0000);
		send(OP_ACQ_START, 3'h1, 16'h0000, 1'b0);
		note(5'h0e, 16'h0001);
		send(OP_ACQ_STOP, 3'h1, 16'h0000, 1'b0);
		note(5'h0e, 16'h0000);
		send(OP_STATE, 3'h1, 16'h0000, 1'b0);
		note(5'h0d, 16'h0000);
		send(OP_ACQ_START, 3'h1, 16'h0000, 1'b0);
		note(5'h0e, 16'h0000);
		send(OP_ACQ_STOP, 3'h1, 16'h0000, 1'b0);
		note(5'h06, 16'h0001);
		send(OP_LOCK, 3'h1, 16'h0001, 1'b1);
		note(5'h0f, 16'h0001);
		note(5'h10, 16'h0000);
		send(OP_LOCK, 3'h1, 16'h0000, 1'b1);
		note(5'h0f, 16'h0000);
		send(OP_LOCK, 3'h1, 16'h0001, 1'b0);
		note(5'h10, 16'h0001);
		pulse(7'h40);
		note(5'h0f, 16'h0000);
		send(OP_LOCK, 3'h1, 16'h0001, 1'b0);
		send(OP_LOCK, 3'h1, 16'h0000, 1'b0);
		note(5'h0f, 16'h0000);
		// Channel 1 is made to fail so a stuck status cannot pass for a result.
		tune_fail = 3'h1;
		send(OP_STATE, 3'h1, 16'h0003, 1'b0);
		note(5'h1d, 16'h0002);
		repeat (2200) @(posedge clk);
		note(5'h15, 16'h0031);
		send(OP_HEAT, 3'h1, 16'h0000, 1'b0);
		note(5'h16, 16'h0001);
		note(5'h17, 16'h0001);
		summarize();
	end
endmodule
`default_nettype wire
